// >>> design/dpw_params.svh
// Constants for the data paging and nonvolatile write controller.
// Assumes an 8-bit data space and a 12-bit program space.
`ifndef DPW_PARAMS_SVH
`define DPW_PARAMS_SVH
// Register addresses in data space
`define ADDR_WINDOW_SEL 8'hc9
`define ADDR_BANK_SEL 8'he8
`define ADDR_NVM_CTRL 8'hea
// Data space regions
`define BANK_REGION_LO 8'h00
`define BANK_REGION_HI 8'h3f
`define WINDOW_LO 8'h40
`define WINDOW_HI 8'h7f
// Bank select field positions
`define BANK_NVM0_BIT 0
`define BANK_NVM1_BIT 1
`define BANK_RAM2_BIT 4
// Control field positions
`define CTL_ENABLE_BIT 0
`define CTL_BUSY_BIT 1
`define CTL_ROW_EN_BIT 2
`define CTL_ROW_GO_BIT 3
`define CTL_STANDBY_BIT 6
// Control reset value
`define CTL_RESET 8'h00
// Cell write time in ns and cycles at 25 MHz
`define CELL_WRITE_NS 5000
`define CLK_PERIOD_NS 40
`define CELL_WRITE_CYCLES ((`CELL_WRITE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// >>> design/dpw_pkg.sv
// Types shared by the paging and nonvolatile write controller.
// Assumes dpw_params.svh supplies the numbers.
package dpw_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [6:0] nvm_addr_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_BYTE = 2'b01,
        ST_ROW = 2'b10
    } prog_state_t;
endpackage : dpw_pkg

// >>> design/nvm_array.sv
// Nonvolatile cell array: 128 bytes, registered read, byte write port.
// Assumes the controller sequences all writes.
`timescale 1ns/1ps
`default_nettype none
module nvm_array (
    // Clock
    input wire logic mclk,
    // Read port
    input wire dpw_pkg::nvm_addr_t rd_addr,
    output dpw_pkg::byte_t rd_data,
    // Write port
    input wire logic wr_en,
    input wire dpw_pkg::nvm_addr_t wr_addr,
    input wire dpw_pkg::byte_t wr_data
);
    import dpw_pkg::*;
    byte_t mem [0:127]; // Cell contents
    // Registered read and write
    always_ff @(posedge mclk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule : nvm_array
`default_nettype wire

// >>> design/row_latch.sv
// Eight-byte row latch with per-byte written marks.
// Assumes the controller clears it on row mode entry.
`timescale 1ns/1ps
`default_nettype none
module row_latch (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Control
    input wire logic clear,
    input wire logic load,
    input wire logic [2:0] load_idx,
    input wire dpw_pkg::byte_t load_data,
    // Contents
    input wire logic [2:0] sel_idx,
    output dpw_pkg::byte_t sel_data,
    output logic [7:0] marks
);
    import dpw_pkg::*;
    byte_t data [0:7]; // Latched bytes
    assign sel_data = data[sel_idx];
    // Marks and data
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            marks <= 8'h00;
        end else if (clear) begin
            marks <= 8'h00;
        end else if (load) begin
            marks[load_idx] <= 1'b1;
        end
    end
    always_ff @(posedge mclk) begin
        if (load && !clear) begin
            data[load_idx] <= load_data;
        end
    end
endmodule : row_latch
`default_nettype wire

// >>> design/page_nvm_ctrl.sv
// Data space paging and nonvolatile write controller.
// Assumes a core issuing one-cycle read/write strobes; read data one cycle later.
// Notes on behaviour
// - Window register: six bits, upper program address
// - Program address is window above six low bits
// - Window register undefined at reset, write only; this block's reset clears it to zero
// - Bank bit 4 selects second RAM page
// - Bank bits 0/1 select nonvolatile pages
// - Selected page overlays region 00h to 3Fh
// - Bank register uncleared, unreadable, write first; this block's reset clears it to zero
// - Interrupts and calls leave bank register alone
// - No bank or standby: access has no effect
// - Cell programming needs program enable set
// - Busy held during programming; accesses meaningless
// - Idle nonvolatile read like ordinary data
// - Byte writes and eight-byte row writes
// - Row is eight bytes, low three bits vary
// - Writes go directly to addressed location
// - Control writes ignored while busy
// - Stop instruction disables the nonvolatile store
// - Row address and data latched in row mode
// - Only the latched row is visible
// - Row mode entry clears latches; unwritten bytes kept
// - Start bit begins row programming, self-clears
// - Row mode enable self-clears at cycle end
// - Start needs program enable and row enable
`timescale 1ns/1ps
`default_nettype none
`include "dpw_params.svh"
module page_nvm_ctrl #(
    parameter int unsigned CELL_CYCLES = `CELL_WRITE_CYCLES
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Core data space access
    input wire dpw_pkg::byte_t core_addr,
    input wire logic core_wr,
    input wire logic core_rd,
    input wire dpw_pkg::byte_t core_wdata,
    input wire logic stop_exec,
    // Program memory window port
    output logic [11:0] prog_addr,
    output logic prog_rd,
    // Extra RAM page port
    output logic [5:0] ram2_addr,
    output logic ram2_wr,
    output logic ram2_rd,
    output dpw_pkg::byte_t ram2_wdata,
    // Bank region claim towards base RAM
    output logic bank_claim,
    // Read data of this block
    output dpw_pkg::byte_t rdata,
    output logic rdata_valid,
    // Status
    output logic nvm_busy_flag
);
    import dpw_pkg::*;

    // Whole block state
    typedef struct packed {
        logic [5:0] window_page_bits;   // Window page
        byte_t bank;                    // Bank select
        logic nvm_standby;
        logic nvm_program_enable;
        logic row_mode_enable;
        logic row_program_start;
        logic [6:3] row_addr;           // Latched row: page bit and row number
        logic row_addr_valid;
        prog_state_t state;
        logic [12:0] cnt;               // Write time counter
        nvm_addr_t byte_addr;           // Byte mode target
        byte_t byte_data;
        logic [2:0] row_idx;            // Row commit index
        logic [11:0] prog_addr;
        logic prog_rd;
        logic [5:0] ram2_addr;
        logic ram2_wr;
        logic ram2_rd;
        byte_t ram2_wdata;
        logic bank_claim;
        logic ctl_rd;                   // Control read pending
        logic nvm_rd;                   // Array read pending
        logic rdata_valid;
        logic busy;
    } state_t;

    state_t s_q, s_d;

    // Helper: address inside a range
    function automatic logic in_range(input byte_t a, input byte_t lo, input byte_t hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction : in_range

    // Helper: nonvolatile array address from page bit and offset
    function automatic nvm_addr_t nvm_index(input logic page1, input logic [5:0] off);
        nvm_index = {page1, off};
    endfunction : nvm_index

    // Array and row latch wiring
    nvm_addr_t arr_rd_addr;
    nvm_addr_t arr_wr_addr;
    byte_t arr_rd_data;
    byte_t arr_wr_data;
    logic arr_wr_en;
    logic latch_clear;
    logic latch_load;
    byte_t latch_sel_data;
    logic [7:0] latch_marks;

    logic in_bank;
    logic nvm_sel;
    logic nvm_page1;
    logic nvm_live;
    logic cnt_done;

    // Decode of the bank region
    always_comb begin
        in_bank = in_range(core_addr, `BANK_REGION_LO, `BANK_REGION_HI);
        nvm_page1 = s_q.bank[`BANK_NVM1_BIT];
        nvm_sel = s_q.bank[`BANK_NVM0_BIT] | s_q.bank[`BANK_NVM1_BIT];
        nvm_live = nvm_sel && !s_q.nvm_standby && !s_q.busy;
        cnt_done = (s_q.cnt == 13'(CELL_CYCLES - 1));
    end

    assign arr_rd_addr = nvm_index(nvm_page1, core_addr[5:0]);
    assign latch_clear = core_wr && core_addr == `ADDR_NVM_CTRL && !s_q.busy
        && core_wdata[`CTL_ROW_EN_BIT] && !s_q.row_mode_enable;
    assign latch_load = core_wr && in_bank && nvm_live && s_q.row_mode_enable
        && !s_q.row_program_start
        && (!s_q.row_addr_valid || core_addr[5:3] == s_q.row_addr[5:3]
            && nvm_page1 == s_q.row_addr[6]);

    // Row commit and byte write into the array
    always_comb begin
        arr_wr_en = 1'b0;
        arr_wr_addr = s_q.byte_addr;
        arr_wr_data = s_q.byte_data;
        if (s_q.state == ST_BYTE && cnt_done) begin
            arr_wr_en = 1'b1;
        end else if (s_q.state == ST_ROW && cnt_done) begin
            arr_wr_en = latch_marks[s_q.row_idx];
            arr_wr_addr = {s_q.row_addr, s_q.row_idx};
            arr_wr_data = latch_sel_data;
        end
    end

    nvm_array u_array (
        .mclk(mclk),
        .rd_addr(arr_rd_addr),
        .rd_data(arr_rd_data),
        .wr_en(arr_wr_en),
        .wr_addr(arr_wr_addr),
        .wr_data(arr_wr_data)
    );

    row_latch u_row (
        .mclk(mclk),
        .reset_n(reset_n),
        .clear(latch_clear),
        .load(latch_load),
        .load_idx(core_addr[2:0]),
        .load_data(core_wdata),
        .sel_idx(s_q.row_idx),
        .sel_data(latch_sel_data),
        .marks(latch_marks)
    );

    // Next state of the whole block
    always_comb begin
        s_d = s_q;
        s_d.prog_rd = 1'b0;
        s_d.ram2_wr = 1'b0;
        s_d.ram2_rd = 1'b0;
        s_d.ctl_rd = 1'b0;
        s_d.nvm_rd = 1'b0;
        s_d.bank_claim = 1'b0;
        // Paging registers: write only, no read path
        if (core_wr && core_addr == `ADDR_WINDOW_SEL) begin
            s_d.window_page_bits = core_wdata[5:0];
        end
        if (core_wr && core_addr == `ADDR_BANK_SEL) begin
            s_d.bank = core_wdata;
        end
        // Window read towards program memory
        if (core_rd && in_range(core_addr, `WINDOW_LO, `WINDOW_HI)) begin
            s_d.prog_addr = {s_q.window_page_bits, core_addr[5:0]};
            s_d.prog_rd = 1'b1;
        end
        // Bank region access
        if ((core_rd || core_wr) && in_bank) begin
            if (s_q.bank[`BANK_RAM2_BIT]) begin
                s_d.bank_claim = 1'b1;
                s_d.ram2_addr = core_addr[5:0];
                s_d.ram2_wr = core_wr;
                s_d.ram2_rd = core_rd;
                s_d.ram2_wdata = core_wdata;
            end else if (nvm_sel) begin
                s_d.bank_claim = 1'b1;
                // Standby or busy: the read returns nothing
                s_d.nvm_rd = core_rd && nvm_live;
            end
        end
        // Control register read
        if (core_rd && core_addr == `ADDR_NVM_CTRL) begin
            s_d.ctl_rd = 1'b1;
        end
        // Control register write, ignored while busy
        if (core_wr && core_addr == `ADDR_NVM_CTRL && !s_q.busy) begin
            s_d.nvm_standby = core_wdata[`CTL_STANDBY_BIT];
            s_d.nvm_program_enable = core_wdata[`CTL_ENABLE_BIT];
            s_d.row_mode_enable = core_wdata[`CTL_ROW_EN_BIT];
            if (!core_wdata[`CTL_ROW_EN_BIT] || !s_q.row_mode_enable) begin
                s_d.row_addr_valid = 1'b0;
            end
            // Start only with enable and row mode already set
            if (core_wdata[`CTL_ROW_GO_BIT] && core_wdata[`CTL_ENABLE_BIT]
                && s_q.nvm_program_enable && s_q.row_mode_enable
                && core_wdata[`CTL_ROW_EN_BIT] && !s_q.nvm_standby) begin
                s_d.row_program_start = 1'b1;
                s_d.busy = 1'b1;
                s_d.state = ST_ROW;
                s_d.cnt = 13'h0000;
                s_d.row_idx = 3'h0;
            end
        end
        // Row latch address capture
        if (latch_load && !s_q.row_addr_valid) begin
            s_d.row_addr = {nvm_page1, core_addr[5:3]};
            s_d.row_addr_valid = 1'b1;
        end
        // Byte mode write launches a cycle
        if (core_wr && in_bank && nvm_live && !s_q.bank[`BANK_RAM2_BIT]
            && s_q.nvm_program_enable && !s_q.row_mode_enable) begin
            s_d.byte_addr = arr_rd_addr;
            s_d.byte_data = core_wdata;
            s_d.busy = 1'b1;
            s_d.state = ST_BYTE;
            s_d.cnt = 13'h0000;
        end
        // Programming cycle sequencer
        case (s_q.state)
            ST_IDLE: begin
                s_d.cnt = 13'h0000;
            end
            ST_BYTE: begin
                s_d.cnt = s_q.cnt + 13'h0001;
                if (cnt_done) begin
                    s_d.state = ST_IDLE;
                    s_d.busy = 1'b0;
                end
            end
            ST_ROW: begin
                // Wait out the cell time, then commit marked bytes one per cycle
                if (!cnt_done) begin
                    s_d.cnt = s_q.cnt + 13'h0001;
                end else if (s_q.row_idx == 3'h7) begin
                    s_d.state = ST_IDLE;
                    s_d.busy = 1'b0;
                    s_d.row_program_start = 1'b0;
                    s_d.row_mode_enable = 1'b0;
                    s_d.row_addr_valid = 1'b0;
                end else begin
                    s_d.row_idx = s_q.row_idx + 3'h1;
                end
            end
            default: begin
                s_d.state = ST_IDLE;
            end
        endcase
        // Stop instruction puts the store in standby
        if (stop_exec) begin
            s_d.nvm_standby = 1'b1;
        end
        s_d.rdata_valid = s_d.ctl_rd || s_d.nvm_rd;
    end

    // Single register stage for the whole block
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '0;
            s_q.state <= ST_IDLE;
            s_q.nvm_standby <= 1'b0;
            s_q.cnt <= 13'h0000;
        end else begin
            s_q <= s_d;
        end
    end

    // Read data: busy status from control, array data when live
    always_comb begin
        rdata = 8'h00;
        if (s_q.ctl_rd) begin
            rdata[`CTL_BUSY_BIT] = s_q.busy;
        end else if (s_q.nvm_rd) begin
            rdata = arr_rd_data;
        end
    end

    // Outputs straight from state
    assign prog_addr = s_q.prog_addr;
    assign prog_rd = s_q.prog_rd;
    assign ram2_addr = s_q.ram2_addr;
    assign ram2_wr = s_q.ram2_wr;
    assign ram2_rd = s_q.ram2_rd;
    assign ram2_wdata = s_q.ram2_wdata;
    assign bank_claim = s_q.bank_claim;
    assign rdata_valid = s_q.rdata_valid;
    assign nvm_busy_flag = s_q.busy;
endmodule : page_nvm_ctrl
`default_nettype wire

// >>> verif/page_nvm_ctrl_props.sv
// Checker for the paging and nonvolatile write controller.
// Assumes it is bound to page_nvm_ctrl and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module page_nvm_ctrl_props #(
    parameter int unsigned CELL_CYCLES = 4
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Core side
    input wire dpw_pkg::byte_t core_addr,
    input wire logic core_wr,
    input wire logic core_rd,
    input wire dpw_pkg::byte_t core_wdata,
    // Block outputs
    input wire logic [11:0] prog_addr,
    input wire logic prog_rd,
    input wire logic [5:0] ram2_addr,
    input wire logic ram2_wr,
    input wire dpw_pkg::byte_t ram2_wdata,
    input wire logic bank_claim,
    input wire dpw_pkg::byte_t rdata,
    input wire logic rdata_valid,
    input wire logic nvm_busy_flag
);
    import dpw_pkg::*;
    byte_t bank_q; // Shadow of the bank register
    logic [7:0] busy_cnt_q; // Length of the current busy stretch
    // Track bank writes and busy length
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            bank_q <= 8'h00;
            busy_cnt_q <= 8'h00;
        end else begin
            if (core_wr && core_addr == 8'he8) begin
                bank_q <= core_wdata;
            end
            busy_cnt_q <= nvm_busy_flag ? busy_cnt_q + 8'h01 : 8'h00;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    property p_win_read;
        core_rd && core_addr[7:6] == 2'b01 |=> prog_rd && prog_addr[5:0] == $past(core_addr[5:0]);
    endproperty
    a_win_read: assert property (p_win_read) else $error("window read address wrong");
    property p_win_only;
        prog_rd |-> $past(core_rd) && $past(core_addr[7:6]) == 2'b01;
    endproperty
    a_win_only: assert property (p_win_only) else $error("stray window read");
    property p_ram2_wr;
        core_wr && core_addr[7:6] == 2'b00 && bank_q == 8'h10 |=> ram2_wr
            && ram2_addr == $past(core_addr[5:0]) && ram2_wdata == $past(core_wdata);
    endproperty
    a_ram2_wr: assert property (p_ram2_wr) else $error("second page write wrong");
    property p_no_bank;
        (core_wr || core_rd) && core_addr[7:6] == 2'b00 && bank_q == 8'h00 |=> !bank_claim && !ram2_wr;
    endproperty
    a_no_bank: assert property (p_no_bank) else $error("access claimed with no bank");
    property p_busy_cause;
        $rose(nvm_busy_flag) |-> $past(core_wr);
    endproperty
    a_busy_cause: assert property (p_busy_cause) else $error("busy without a write");
    property p_busy_len;
        nvm_busy_flag |-> busy_cnt_q < CELL_CYCLES + 8;
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy too long");
    property p_busy_status;
        nvm_busy_flag && core_rd && core_addr == 8'hea
            |=> rdata_valid && rdata == {6'h00, nvm_busy_flag, 1'b0};
    endproperty
    a_busy_status: assert property (p_busy_status) else $error("busy status read wrong");
    property p_rdv_cause;
        rdata_valid |-> $past(core_rd);
    endproperty
    a_rdv_cause: assert property (p_rdv_cause) else $error("read data without read");
    property p_bank_claim;
        (core_wr || core_rd) && core_addr[7:6] == 2'b00
            && (bank_q == 8'h10 || bank_q == 8'h01 || bank_q == 8'h02) |=> bank_claim;
    endproperty
    a_bank_claim: assert property (p_bank_claim) else $error("bank access not claimed");
endmodule : page_nvm_ctrl_props
bind page_nvm_ctrl page_nvm_ctrl_props #(.CELL_CYCLES(CELL_CYCLES)) u_props (.mclk, .reset_n,
    .core_addr, .core_wr, .core_rd, .core_wdata, .prog_addr, .prog_rd, .ram2_addr, .ram2_wr,
    .ram2_wdata, .bank_claim, .rdata, .rdata_valid, .nvm_busy_flag);
`default_nettype wire

// >>> verif/core_model.sv
// Core model: one-cycle data space reads and writes.
// Assumes the bench calls its task from one process.
`timescale 1ns/1ps
`default_nettype none
module core_model (
    // Clock
    input wire logic mclk,
    // Data space access
    output dpw_pkg::byte_t core_addr,
    output logic core_wr,
    output logic core_rd,
    output dpw_pkg::byte_t core_wdata
);
    import dpw_pkg::*;
    // Idle lines at time zero
    initial begin
        core_addr = 8'h00;
        core_wr = 1'b0;
        core_rd = 1'b0;
        core_wdata = 8'h00;
    end
    // Strobe for one edge, then scramble the released lines
    task automatic access(input byte_t a, input byte_t d, input logic w);
        @(posedge mclk);
        core_addr <= a;
        core_wdata <= d;
        core_wr <= w;
        core_rd <= !w;
        @(posedge mclk);
        core_wr <= 1'b0;
        core_rd <= 1'b0;
        core_addr <= ~a;
        core_wdata <= ~d;
    endtask : access
endmodule : core_model
`default_nettype wire

// >>> verif/tb.sv
// Bench for the paging and nonvolatile write controller.
// Assumes core_model drives the data space side.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import dpw_pkg::*;
    logic mclk, reset_n, stop_exec; // Clock, reset, stop pulse
    byte_t core_addr, core_wdata, ram2_wdata, rdata, w, o, d; // Bus and scratch
    logic core_wr, core_rd, prog_rd, ram2_wr, ram2_rd, bank_claim, rdata_valid, nvm_busy_flag;
    logic [11:0] prog_addr; // Window address
    logic [5:0] ram2_addr; // Page two address
    logic [19:0] expq[$]; // Expected results, kind in top nibble
    int n_mismatch = 0, compares = 0; // Counters
    // Clock at 25 MHz
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    page_nvm_ctrl #(.CELL_CYCLES(8)) u_dut (.mclk, .reset_n, .core_addr, .core_wr, .core_rd,
        .core_wdata, .stop_exec, .prog_addr, .prog_rd, .ram2_addr, .ram2_wr, .ram2_rd,
        .ram2_wdata, .bank_claim, .rdata, .rdata_valid, .nvm_busy_flag);
    core_model u_core (.mclk, .core_addr, .core_wr, .core_rd, .core_wdata);
    // One comparison
    task automatic chk(input logic [19:0] ob, input logic [19:0] ex);
        compares++;
        if (ob !== ex) begin
            n_mismatch++;
            $display("FAIL t=%0t got %h exp %h", $time, ob, ex);
        end
    endtask : chk
    // Access with an optional expected result (zero means none)
    task automatic acc(input byte_t a, input byte_t dd, input logic wr, input logic [19:0] e);
        if (e != 20'h0) expq.push_back(e);
        u_core.access(a, dd, wr);
    endtask : acc
    // Expected read data note
    function automatic logic [19:0] ed(input byte_t x);
        return {4'h2, 8'h00, x};
    endfunction : ed
    // Write, then check busy one cycle later
    task automatic nvm_wr(input byte_t a, input byte_t dd, input logic e);
        acc(a, dd, 1'b1, 20'h0);
        @(posedge mclk);
        #1 chk(20'(nvm_busy_flag), 20'(e));
    endtask : nvm_wr
    // Bounded wait for the end of programming
    task automatic wait_idle;
        for (int i = 0; i < 40 && nvm_busy_flag !== 1'b0; i++) @(posedge mclk);
        #1 chk(20'(nvm_busy_flag), 20'h0);
    endtask : wait_idle
    // Verdict and end of run
    task automatic final_report;
        $display("compares=%0d mismatches=%0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : final_report
    // Match each result with the oldest note
    always @(posedge mclk) begin
        if (reset_n && (prog_rd || rdata_valid || ram2_wr || ram2_rd)) begin
            if (expq.size() == 0) chk(20'hfffff, 20'h0);
            else chk(prog_rd ? {8'h10, prog_addr} : rdata_valid ? ed(rdata) :
                {4'h3, ram2_wr, ram2_rd, ram2_addr, ram2_wr ? ram2_wdata : 8'h00}, expq.pop_front());
        end
    end
    // Hang guard
    initial begin
        #400000;
        n_mismatch++;
        final_report();
    end
    // Main sequence
    initial begin
        reset_n = 1'b0;
        stop_exec = 1'b0;
        void'($urandom(5816));
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        // Window mapping, fixed example then random
        acc(8'hc9, 8'h28, 1'b1, 20'h0);
        acc(8'h59, 8'h00, 1'b0, 20'h10a19);
        for (int i = 0; i < 4; i++) begin
            w = 8'($urandom());
            o = 8'h40 | 8'($urandom_range(63));
            acc(8'hc9, w, 1'b1, 20'h0);
            acc(o, 8'h00, 1'b0, {8'h10, w[5:0], o[5:0]});
        end
        acc(8'hc9, 8'h00, 1'b0, 20'h0);
        $display("test window done");
        // Second RAM page and no bank
        acc(8'he8, 8'h10, 1'b1, 20'h0);
        acc(8'h05, 8'ha5, 1'b1, {6'h0e, 6'h05, 8'ha5});
        acc(8'h3f, 8'h00, 1'b0, {6'h0d, 6'h3f, 8'h00});
        acc(8'he8, 8'h00, 1'b0, 20'h0);
        acc(8'he8, 8'h00, 1'b1, 20'h0);
        acc(8'h05, 8'h00, 1'b0, 20'h0);
        $display("test bank done");
        // Byte writes, busy status, ignored control write
        d = 8'($urandom());
        acc(8'he8, 8'h01, 1'b1, 20'h0);
        acc(8'hea, 8'h01, 1'b1, 20'h0);
        nvm_wr(8'h05, d, 1'b1);
        acc(8'hea, 8'h00, 1'b0, ed(8'h02));
        acc(8'hea, 8'h40, 1'b1, 20'h0);
        wait_idle();
        acc(8'h05, 8'h00, 1'b0, ed(d));
        nvm_wr(8'h19, 8'h44, 1'b1);
        wait_idle();
        acc(8'hea, 8'h00, 1'b1, 20'h0);
        nvm_wr(8'h05, 8'h77, 1'b0);
        acc(8'h05, 8'h00, 1'b0, ed(d));
        acc(8'he8, 8'h02, 1'b1, 20'h0);
        acc(8'hea, 8'h01, 1'b1, 20'h0);
        nvm_wr(8'h05, 8'h3c, 1'b1);
        wait_idle();
        acc(8'h05, 8'h00, 1'b0, ed(8'h3c));
        acc(8'he8, 8'h01, 1'b1, 20'h0);
        acc(8'h05, 8'h00, 1'b0, ed(d));
        $display("test byte done");
        // Standby and stop silence the store
        acc(8'hea, 8'h40, 1'b1, 20'h0);
        acc(8'h05, 8'h00, 1'b0, 20'h0);
        acc(8'hea, 8'h01, 1'b1, 20'h0);
        @(posedge mclk) stop_exec <= 1'b1;
        @(posedge mclk) stop_exec <= 1'b0;
        acc(8'h05, 8'h00, 1'b0, 20'h0);
        acc(8'hea, 8'h01, 1'b1, 20'h0);
        $display("test standby done");
        // Row write: start refused without enable, then partial row
        acc(8'hea, 8'h04, 1'b1, 20'h0);
        nvm_wr(8'hea, 8'h0c, 1'b0);
        acc(8'hea, 8'h05, 1'b1, 20'h0);
        acc(8'h18, 8'ha1, 1'b1, 20'h0);
        acc(8'h1a, 8'ha2, 1'b1, 20'h0);
        acc(8'h1b, 8'ha3, 1'b1, 20'h0);
        acc(8'h21, 8'h99, 1'b1, 20'h0);
        nvm_wr(8'hea, 8'h0d, 1'b1);
        wait_idle();
        acc(8'h18, 8'h00, 1'b0, ed(8'ha1));
        acc(8'h19, 8'h00, 1'b0, ed(8'h44));
        acc(8'h1b, 8'h00, 1'b0, ed(8'ha3));
        acc(8'hea, 8'h00, 1'b0, ed(8'h00));
        $display("test row done");
        repeat (3) @(posedge mclk);
        chk(20'(expq.size()), 20'h0);
        final_report();
    end
endmodule : tb
`default_nettype wire
